// *** src/afzt_cur_cond.sv ***
`timescale 1ns/1ps
`default_nettype none
// counts consecutive over-limit samples; condition holds once count reached
module afzt_cur_cond
#(
    parameter int CNT_W = 4
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // sample strobe and comparison
    input wire logic tick,
    input wire logic over,
    input wire logic [CNT_W-1:0] need,
    // result
    output logic active
);
    logic [CNT_W-1:0] cnt_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_r <= '0;
        else if (tick)
        begin
            if (!over)
                cnt_r <= '0;
            else if (cnt_r != {CNT_W{1'b1}})
                cnt_r <= cnt_r + 1'b1;
        end
    end

    // zero required treated as one; extra bit stops saturated count wrapping
    assign active = over &&
        (({1'b0, cnt_r} + 1'b1) >= {1'b0, need});
endmodule
`default_nettype wire

// *** src/afzt_pkg.sv ***
`default_nettype none
package afzt_pkg;
    typedef struct packed {
        logic [3:0] light;
        logic [3:0] press;
    } afzt_sens_t;
    typedef struct packed {
        logic [15:0] ph_a;
        logic [15:0] ph_b;
        logic [15:0] ph_c;
        logic [15:0] res_one;
        logic [15:0] res_two;
    } afzt_samp_t;
    typedef enum logic [1:0] {
        AFZT_RES_NONE = 2'h0,
        AFZT_RES_ONE = 2'h1,
        AFZT_RES_TWO = 2'h3
    } afzt_res_sel_t;
endpackage
`default_nettype wire

// *** src/afzt_regs.svh ***
`ifndef AFZT_REGS_SVH
`define AFZT_REGS_SVH
// register byte offsets
`define AFZT_OFF_ZONE_EN     12'h000
`define AFZT_OFF_LIGHT_EN    12'h004
`define AFZT_OFF_PRESS_EN    12'h008
`define AFZT_OFF_CURR_CFG    12'h00C
`define AFZT_OFF_SENS_CFG    12'h010
`define AFZT_OFF_LIMITS      12'h014
`define AFZT_OFF_STATUS      12'h018
`define AFZT_OFF_FAULTS      12'h01C
// field positions
`define AFZT_CC_PH_EN_LSB    0
`define AFZT_CC_RES_EN_LSB   4
`define AFZT_CC_RES_SEL_LSB  8
`define AFZT_CC_TEST_PULSE   10
`define AFZT_CC_NSAMP_LSB    16
`define AFZT_LIM_RES_LSB     16
`define AFZT_SC_UNITS_LSB    8
// reset values
`define AFZT_RST_ZERO        32'h0000_0000
`define AFZT_RST_LIMITS      32'h0078_0078
`define AFZT_RST_NSAMP       4'h1
// timing
`define AFZT_SAMPLE_MS       5
`define AFZT_CLK_HZ          10000000
`define AFZT_SAMPLE_CYC      ((`AFZT_SAMPLE_MS * `AFZT_CLK_HZ) / 1000)
`endif

// *** src/afzt_top.sv ***
// How it works
// - four channels, zero to three sensors each
// - per-channel light detected output
// - per-channel pressure detected output
// - binary input indication while energized
// - phase and residual start above limit
// - phase and residual blocked when inhibited
// - zone trips on light, plus current if enabled
// - blocked zone shows blocked, not trip
// - sensor fault on count mismatch
// - io unit fault on unit count mismatch
// - enabled current needed alongside light
// - current condition after required sample count
// - phase, residual or both selectable
// - five current channels sampled every 5 ms
// - test pulse setting masks binary input
// - per-zone enable, per-zone channel light enables
// - per-zone channel pressure enables
// - sensor count per channel, default zero
// - four zones, all disabled at reset
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "afzt_regs.svh"
module afzt_top
    import afzt_pkg::*;
#(
    parameter int NCH = 4,
    parameter int NZONE = 4,
    parameter int SAMPLE_CYC = `AFZT_SAMPLE_CYC,
    parameter int NSAMP_W = 4
)
(
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // sensor channels
    input wire afzt_sens_t sens,
    input wire logic [1:0] sens_count_0,
    input wire logic [1:0] sens_count_1,
    input wire logic [1:0] sens_count_2,
    input wire logic [1:0] sens_count_3,
    input wire logic [3:0] io_unit_count,
    input wire logic arc_binary_input_one,
    input wire logic test_pulse,
    // current samples and blocking
    input wire afzt_samp_t samp,
    input wire logic block_ph,
    input wire logic block_res,
    input wire logic [3:0] block_zone,
    // indications
    output logic [3:0] light_det_r,
    output logic [3:0] press_det_r,
    output logic arc_bin_ind_r,
    output logic ph_start_r,
    output logic res_start_r,
    output logic ph_blocked_r,
    output logic res_blocked_r,
    output logic [3:0] zone_trip_r,
    output logic [3:0] zone_blocked_r,
    output logic [3:0] sens_fault_r,
    output logic io_unit_fault_r
);
    // refuse counts and widths the fixed register map cannot serve
    if (NCH != 4 || NZONE != 4 || SAMPLE_CYC < 1 || NSAMP_W < 1 ||
        NSAMP_W > 16)
    begin : g_bad_param
        $error("afzt_top: unsupported parameters");
    end

    // configuration
    logic [3:0] zone_en_r;
    logic [15:0] light_en_r;
    logic [15:0] press_en_r;
    logic [31:0] curr_cfg_r;
    logic [31:0] sens_cfg_r;
    logic [31:0] limits_r;

    logic acc_wr;
    assign acc_wr = psel && penable && pwrite && pready;

    // writes land at the access edge, where the master sees pready
    // a setup-edge write would land before the transfer is complete
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            zone_en_r <= 4'h0;
            light_en_r <= 16'h0000;
            press_en_r <= 16'h0000;
            curr_cfg_r <= `AFZT_RST_ZERO;
            sens_cfg_r <= `AFZT_RST_ZERO;
            limits_r <= `AFZT_RST_LIMITS;
        end
        else if (acc_wr)
        begin
            unique case (paddr)
                `AFZT_OFF_ZONE_EN: zone_en_r <= pwdata[3:0];
                `AFZT_OFF_LIGHT_EN: light_en_r <= pwdata[15:0];
                `AFZT_OFF_PRESS_EN: press_en_r <= pwdata[15:0];
                `AFZT_OFF_CURR_CFG: curr_cfg_r <= pwdata;
                `AFZT_OFF_SENS_CFG: sens_cfg_r <= pwdata;
                `AFZT_OFF_LIMITS: limits_r <= pwdata;
                default: ;
            endcase
        end
    end

    function automatic logic addr_ok(input logic [11:0] a);
        addr_ok = (a <= `AFZT_OFF_FAULTS) && (a[1:0] == 2'h0);
    endfunction

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok(paddr);
            prdata <= 32'h0000_0000;
            if (psel && !penable && !pwrite)
            begin
                unique case (paddr)
                    `AFZT_OFF_ZONE_EN: prdata <= {28'h0, zone_en_r};
                    `AFZT_OFF_LIGHT_EN: prdata <= {16'h0, light_en_r};
                    `AFZT_OFF_PRESS_EN: prdata <= {16'h0, press_en_r};
                    `AFZT_OFF_CURR_CFG: prdata <= curr_cfg_r;
                    `AFZT_OFF_SENS_CFG: prdata <= sens_cfg_r;
                    `AFZT_OFF_LIMITS: prdata <= limits_r;
                    `AFZT_OFF_STATUS: prdata <= {11'h000, zone_blocked_r,
                        zone_trip_r, res_blocked_r, ph_blocked_r,
                        res_start_r, ph_start_r, arc_bin_ind_r,
                        press_det_r, light_det_r};
                    `AFZT_OFF_FAULTS: prdata <= {27'h0, io_unit_fault_r,
                        sens_fault_r};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // sample time base
    // 32-bit counter so a full 5 ms span fits at any sane clock
    logic [31:0] tb_cnt_r;
    logic tick;
    assign tick = (tb_cnt_r == 32'(SAMPLE_CYC - 1));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tb_cnt_r <= 32'h0000_0000;
        else if (tick)
            tb_cnt_r <= 32'h0000_0000;
        else
            tb_cnt_r <= tb_cnt_r + 32'h0000_0001;
    end

    // samples latched each 5 ms tick
    afzt_samp_t samp_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            samp_r <= '0;
        else if (tick)
            samp_r <= samp;
    end

    logic [15:0] ph_lim;
    logic [15:0] res_lim;
    logic [1:0] res_sel;
    logic [NSAMP_W-1:0] need;
    assign ph_lim = limits_r[15:0];
    assign res_lim = limits_r[`AFZT_LIM_RES_LSB +: 16];
    assign res_sel = curr_cfg_r[`AFZT_CC_RES_SEL_LSB +: 2];
    assign need = curr_cfg_r[`AFZT_CC_NSAMP_LSB +: NSAMP_W];

    logic ph_over;
    logic res_over;
    assign ph_over = (samp_r.ph_a > ph_lim) || (samp_r.ph_b > ph_lim) ||
        (samp_r.ph_c > ph_lim);
    // residual channel picked by selection; none never picks up
    always_comb
    begin
        unique case (afzt_res_sel_t'(res_sel))
            AFZT_RES_ONE: res_over = samp_r.res_one > res_lim;
            AFZT_RES_TWO: res_over = samp_r.res_two > res_lim;
            default: res_over = 1'b0;
        endcase
    end

    // one counter per current family keeps their runs independent
    logic ph_cond;
    logic res_cond;
    afzt_cur_cond #(.CNT_W(NSAMP_W)) u_ph_cond
    (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .over(ph_over),
        .need(need),
        .active(ph_cond)
    );
    afzt_cur_cond #(.CNT_W(NSAMP_W)) u_res_cond
    (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .over(res_over),
        .need(need),
        .active(res_cond)
    );

    logic [1:0] sens_count [NCH];
    assign sens_count[0] = sens_count_0;
    assign sens_count[1] = sens_count_1;
    assign sens_count[2] = sens_count_2;
    assign sens_count[3] = sens_count_3;

    // indications and faults follow inputs, updated every cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            light_det_r <= 4'h0;
            press_det_r <= 4'h0;
            arc_bin_ind_r <= 1'b0;
            sens_fault_r <= 4'h0;
            io_unit_fault_r <= 1'b0;
            ph_start_r <= 1'b0;
            res_start_r <= 1'b0;
            ph_blocked_r <= 1'b0;
            res_blocked_r <= 1'b0;
        end
        else
        begin
            light_det_r <= sens.light;
            press_det_r <= sens.press;
            // wiring test pulses must not look like an energized input
            arc_bin_ind_r <= arc_binary_input_one && !(test_pulse &&
                curr_cfg_r[`AFZT_CC_TEST_PULSE]);
            for (int c = 0; c < NCH; c++)
                sens_fault_r[c] <= sens_count[c] !=
                    sens_cfg_r[2*c +: 2];
            io_unit_fault_r <= io_unit_count !=
                sens_cfg_r[`AFZT_SC_UNITS_LSB +: 4];
            ph_start_r <= ph_cond && !block_ph;
            res_start_r <= res_cond && !block_res;
            ph_blocked_r <= ph_cond && block_ph;
            res_blocked_r <= res_cond && block_res;
        end
    end

    // zone decision
    // zones ignore block_ph and block_res; only block_zone holds one back
    genvar z;
    generate
        for (z = 0; z < NZONE; z++)
        begin : g_zone
            logic src;
            logic ph_ok;
            logic res_ok;
            logic meet;
            assign src = |((sens.light & light_en_r[4*z +: 4]) |
                (sens.press & press_en_r[4*z +: 4]));
            assign ph_ok = !curr_cfg_r[`AFZT_CC_PH_EN_LSB + z] ||
                ph_cond;
            assign res_ok = !curr_cfg_r[`AFZT_CC_RES_EN_LSB + z] ||
                res_cond;
            assign meet = zone_en_r[z] && src && ph_ok && res_ok;

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    zone_trip_r[z] <= 1'b0;
                    zone_blocked_r[z] <= 1'b0;
                end
                else
                begin
                    zone_trip_r[z] <= meet && !block_zone[z];
                    zone_blocked_r[z] <= meet && block_zone[z];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// *** test/afzt_chk_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module afzt_chk
    import afzt_pkg::*;
(
    // clock and apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // field inputs
    input wire afzt_sens_t sens,
    input wire logic block_ph,
    input wire logic [3:0] block_zone,
    // indications
    input wire logic [3:0] light_det_r,
    input wire logic [3:0] press_det_r,
    input wire logic ph_start_r,
    input wire logic ph_blocked_r,
    input wire logic [3:0] zone_trip_r,
    input wire logic [3:0] zone_blocked_r
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_light_follow: assert property ($past(presetn)
        |-> light_det_r == $past(sens.light)) else $error("light lag");
    a_press_follow: assert property ($past(presetn)
        |-> press_det_r == $past(sens.press)) else $error("press lag");
    a_trip_excl: assert property (
        (zone_trip_r & zone_blocked_r) == 4'h0) else $error("trip+blk");
    a_zone_block: assert property ($past(presetn)
        |-> (zone_trip_r & $past(block_zone)) == 4'h0) else $error("zblk");
    a_ph_block: assert property (ph_blocked_r
        |-> $past(block_ph)) else $error("ph blocked w/o block");
    a_ph_start: assert property (ph_start_r
        |-> !$past(block_ph)) else $error("ph start while blocked");
    a_zone_drop: assert property ($past(presetn)
        && $past((sens.light | sens.press) == 4'h0)
        |-> (zone_trip_r | zone_blocked_r) == 4'h0) else $error("no drop");
    a_apb_ready: assert property (psel && !penable
        |=> pready) else $error("pready late");
endmodule
`default_nettype wire

// *** test/afzt_field.sv ***
`timescale 1ns/1ps
`default_nettype none
module afzt_field
    import afzt_pkg::*;
(
    // commands
    input wire logic [3:0] light,
    input wire logic [3:0] press,
    input wire logic [15:0] ph_lvl,
    input wire logic [15:0] res_lvl,
    // sensor and sample lines
    output afzt_sens_t sens,
    output afzt_samp_t samp
);
    assign sens = '{light: light, press: press};
    // quiet channels sit low but nonzero so any-phase logic is exercised
    assign samp = '{ph_a: 16'h0010, ph_b: ph_lvl, ph_c: 16'h0020,
        res_one: 16'h0030, res_two: res_lvl};
endmodule
`default_nettype wire

// *** test/test_arc_fault_zone_trip_logic.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "afzt_regs.svh"
module test_arc_fault_zone_trip_logic;
    import afzt_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] light, press, bz, iouc, ldet, pdet, ztrip, zblk, sflt;
    logic [15:0] ph_lvl, res_lvl;
    logic [1:0] sc0, sc1, sc2, sc3;
    logic bin, tp, bph, bres, bind_r, phs, rss, phb, rsb, iof;
    afzt_sens_t sens;
    afzt_samp_t samp;
    int n_mismatch = 0;
    int samples_checked = 0;
    logic [3:0] lt[6] = '{4'h2, 4'h4, 4'h8, 4'h0, 4'h2, 4'h1};
    logic [3:0] pt[6] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0};
    logic [3:0] bt[6] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h0};
    logic [7:0] et[6] = '{8'h01, 8'h02, 8'h00, 8'h08, 8'h10, 8'h00};
    afzt_field fld (.light(light), .press(press), .ph_lvl(ph_lvl),
        .res_lvl(res_lvl), .sens(sens), .samp(samp));
    afzt_top #(.SAMPLE_CYC(4)) uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sens(sens), .sens_count_0(sc0),
        .sens_count_1(sc1), .sens_count_2(sc2), .sens_count_3(sc3),
        .io_unit_count(iouc), .arc_binary_input_one(bin), .test_pulse(tp),
        .samp(samp), .block_ph(bph), .block_res(bres), .block_zone(bz),
        .light_det_r(ldet), .press_det_r(pdet), .arc_bin_ind_r(bind_r),
        .ph_start_r(phs), .res_start_r(rss), .ph_blocked_r(phb),
        .res_blocked_r(rsb), .zone_trip_r(ztrip), .zone_blocked_r(zblk),
        .sens_fault_r(sflt), .io_unit_fault_r(iof));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // one transfer, then an idle edge so psel is never driven twice
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [31:0] eq, input logic ee);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        chk(pslverr, ee);
        if (!w)
            chk(prdata, eq);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic close_out();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial
    begin
        #2000000;
        n_mismatch++;
        close_out();
    end
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {light, press, bz, iouc, ph_lvl, res_lvl} = '0;
        {sc0, sc1, sc2, sc3, bin, tp, bph, bres} = '0;
        wt(6);
        presetn <= 1'b1;
        wt(1);
        apb(1'b0, `AFZT_OFF_ZONE_EN, 0, 0, 0);
        apb(1'b0, `AFZT_OFF_SENS_CFG, 0, 0, 0);
        apb(1'b0, `AFZT_OFF_LIMITS, 0, `AFZT_RST_LIMITS, 0);
        apb(1'b0, 12'h020, 0, 0, 1);
        chk({iof, sflt}, 5'h00);
        $display("test reset done");
        light <= 4'h5;
        press <= 4'hA;
        bin <= 1'b1;
        tp <= 1'b1;
        wt(2);
        chk({ldet, pdet, bind_r}, 9'h0B5);
        apb(1'b1, `AFZT_OFF_CURR_CFG, 32'h400, 0, 0);
        wt(2);
        chk(bind_r, 1'b0);
        apb(1'b0, `AFZT_OFF_STATUS, 0, 32'h0A5, 0);
        $display("test indications done");
        apb(1'b1, `AFZT_OFF_SENS_CFG, 32'h239, 0, 0);
        {sc1, sc2, iouc} <= {2'h2, 2'h3, 4'h2};
        wt(2);
        chk({iof, sflt}, 5'h01);
        iouc <= 4'h3;
        wt(2);
        apb(1'b0, `AFZT_OFF_FAULTS, 0, 32'h11, 0);
        $display("test faults done");
        {light, press, bin, tp} <= '0;
        apb(1'b1, `AFZT_OFF_CURR_CFG, 0, 0, 0);
        apb(1'b1, `AFZT_OFF_ZONE_EN, 32'hB, 0, 0);
        apb(1'b1, `AFZT_OFF_LIGHT_EN, 32'h842, 0, 0);
        apb(1'b1, `AFZT_OFF_PRESS_EN, 32'h1000, 0, 0);
        for (int i = 0; i < 6; i++)
        begin
            {light, press, bz} <= {lt[i], pt[i], bt[i]};
            wt(3);
            chk({zblk, ztrip}, et[i]);
        end
        $display("test zones done");
        apb(1'b1, `AFZT_OFF_CURR_CFG, 32'h20321, 0, 0);
        {bz, light, ph_lvl, res_lvl} <= {4'h0, 4'h6, 16'h78, 16'h78};
        wt(12);
        chk({phs, ztrip}, 5'h00);
        ph_lvl <= 16'h79;
        wt(3);
        chk(phs, 1'b0);
        wt(12);
        chk({phs, ztrip}, 5'h11);
        res_lvl <= 16'h79;
        wt(15);
        chk({rss, ztrip}, 5'h13);
        {bph, bres} <= 2'h3;
        wt(6);
        chk({phb, rsb, phs, rss}, 4'hC);
        {bph, bres, ph_lvl, res_lvl} <= {2'h0, 16'h78, 16'h78};
        wt(12);
        chk({phb, rsb, phs, rss, ztrip}, 8'h00);
        $display("test currents done");
        close_out();
    end
endmodule
bind afzt_top afzt_chk chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready), .sens(sens),
    .block_ph(block_ph), .block_zone(block_zone),
    .light_det_r(light_det_r), .press_det_r(press_det_r),
    .ph_start_r(ph_start_r), .ph_blocked_r(ph_blocked_r),
    .zone_trip_r(zone_trip_r), .zone_blocked_r(zone_blocked_r));
`default_nettype wire
